// File: logic/mpc_core.sv
// pwm time base with run/direction control and two output pairs
// assumes single ahb-lite master, whole-word single transfers
`timescale 1ns/1ns
`default_nettype none
`include "mpc_regs.svh"
// Notes on behaviour
// [R01] mode 11 counts up and down and flags an interrupt at both turns.
// [R02] mode 00 counts up repeatedly from zero giving edge-aligned output.
// [R03] pair a bit 1 drives outputs 0 and 1 independently, 0 as complements.
// [R04] pair b bit 1 drives outputs 2 and 3 independently, 0 as complements.
// [R05] the counter advances only while the run bit is set.
// [R06] clearing the run bit keeps the count where it was.
// [R07] complementary outputs are inverse with a dead gap between switches.
// [R08] up/down modes are center-aligned, free-running is edge-aligned.
// [R09] a read-only direction flag in the run register shows counting down.
module mpc_core #(
   parameter int CW = 12
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   output logic             pulse_out_0,
   output logic             pulse_out_1,
   output logic             pulse_out_2,
   output logic             pulse_out_3
);
   import mpc_pkg::*;
   // =====================================
   // bus address phase capture
   logic          wr_q, rd_q;
   logic [11:0]   adr_q;
   wire  logic    take_w = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         adr_q <= 12'h000;
      end else begin
         wr_q  <= take_w && hwrite;
         rd_q  <= take_w && !hwrite;
         adr_q <= take_w ? haddr : adr_q;
      end
   end
   // =====================================
   // registers
   logic [7:0]    mode_q, run_q, pair_q;
   logic [CW-1:0] per_q, duty0_q, duty1_q, cnt_q;
   logic [1:0]    stat_q, mask_q;
   mpc_dir_t      dir_q;
   wire logic     w_mode = wr_q && adr_q == `MPC_OFS_MODE;
   wire logic     w_run  = wr_q && adr_q == `MPC_OFS_RUN;
   wire logic     w_pair = wr_q && adr_q == `MPC_OFS_PAIR;
   wire logic     w_per  = wr_q && adr_q == `MPC_OFS_PERIOD;
   wire logic     w_d0   = wr_q && adr_q == `MPC_OFS_DUTY0;
   wire logic     w_d1   = wr_q && adr_q == `MPC_OFS_DUTY1;
   wire logic     w_mask = wr_q && adr_q == `MPC_OFS_IRQ_MASK;
   // cleared in the data phase, at the edge that loads hrdata
   wire logic     r_stat = rd_q && adr_q == `MPC_OFS_IRQ_STAT;
   wire mpc_mode_t mode_w = mpc_mode_t'(mode_q[`MPC_MODE_LSB +: 2]);
   wire logic     run_w  = run_q[`MPC_RUN_BIT];
   wire logic     ud_w   = mode_q[`MPC_MODE_LSB+1];
   wire logic     at_top = cnt_q >= per_q;
   wire logic     at_bot = cnt_q == '0;
   // =====================================
   // time base
   wire logic     turn_dn = run_w && ud_w && dir_q == MPC_UP && at_top;
   wire logic     turn_up = run_w && ud_w && dir_q == MPC_DOWN && at_bot;
   wire logic     top_ev  = run_w && (ud_w ? turn_dn : at_top);
   wire logic     bot_ev  = turn_up && mode_w == MPC_UD_DB; // R01
   logic [CW-1:0] cnt_d;
   mpc_dir_t      dir_d;
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (!run_w) begin
         cnt_d = cnt_q; // R05 R06
      end else if (!ud_w) begin
         dir_d = MPC_UP;
         cnt_d = at_top ? '0 : cnt_q + 1'b1; // R02
      end else if (turn_dn) begin
         dir_d = MPC_DOWN;
         cnt_d = cnt_q - 1'b1; // R01
      end else if (turn_up) begin
         dir_d = MPC_UP;
         cnt_d = cnt_q + 1'b1; // R01
      end else begin
         cnt_d = dir_q == MPC_UP ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q  <= `MPC_RST_MODE;
         run_q   <= `MPC_RST_RUN;
         pair_q  <= `MPC_RST_PAIR;
         per_q   <= `MPC_RST_PERIOD;
         duty0_q <= `MPC_RST_DUTY;
         duty1_q <= `MPC_RST_DUTY;
         mask_q  <= `MPC_RST_MASK;
         stat_q  <= 2'h0;
         cnt_q   <= '0;
         dir_q   <= MPC_UP;
      end else begin
         mode_q  <= w_mode ? hwdata[7:0] : mode_q;
         run_q   <= w_run ? {hwdata[`MPC_RUN_BIT], 7'h00} : run_q; // R09
         pair_q  <= w_pair ? {5'h00, hwdata[2:0]} : pair_q;
         per_q   <= w_per ? hwdata[CW-1:0] : per_q;
         duty0_q <= w_d0 ? hwdata[CW-1:0] : duty0_q;
         duty1_q <= w_d1 ? hwdata[CW-1:0] : duty1_q;
         mask_q  <= w_mask ? hwdata[1:0] : mask_q;
         // set wins over the read clear
         stat_q  <= (r_stat ? 2'h0 : stat_q) | {bot_ev, top_ev}; // R01
         cnt_q   <= cnt_d;
         dir_q   <= dir_d;
      end
   end
   // =====================================
   // read mux
   wire logic [31:0] rd_w =
      adr_q == `MPC_OFS_MODE   ? {24'h0000_00, mode_q} :
      adr_q == `MPC_OFS_RUN    ? {24'h0000_00, run_w,
                                  dir_q == MPC_DOWN, 6'h00} : // R09
      adr_q == `MPC_OFS_PAIR   ? {24'h0000_00, pair_q} :
      adr_q == `MPC_OFS_PERIOD ? {20'h0000_0, per_q} :
      adr_q == `MPC_OFS_DUTY0  ? {20'h0000_0, duty0_q} :
      adr_q == `MPC_OFS_DUTY1  ? {20'h0000_0, duty1_q} :
      adr_q == `MPC_OFS_IRQ_STAT ? {30'h0000_0000, stat_q} :
      adr_q == `MPC_OFS_IRQ_MASK ? {30'h0000_0000, mask_q} :
      adr_q == `MPC_OFS_COUNT  ? {20'h0000_0, cnt_q} : 32'h0000_0000;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         irq       <= 1'b0;
      end else begin
         hrdata    <= rd_q ? rd_w : hrdata;
         hreadyout <= !(take_w && !hwrite);
         hresp     <= 1'b0;
         irq       <= |(stat_q & mask_q);
      end
   end
   // =====================================
   // compare: edge-aligned in free mode, symmetric in up/down modes
   wire logic dem0 = run_w && cnt_q < duty0_q; // R08
   wire logic dem1 = run_w && cnt_q < duty1_q; // R08
   mpc_pair u_pair_a (
      .hclk    (hclk),
      .hresetn (hresetn),
      .indep   (pair_q[`MPC_PAIR_A_BIT]), // R03
      .dem_odd (dem0),
      .dem_even(dem0),
      .out_odd (pulse_out_1),
      .out_even(pulse_out_0)
   );
   mpc_pair u_pair_b (
      .hclk    (hclk),
      .hresetn (hresetn),
      .indep   (pair_q[`MPC_PAIR_B_BIT]), // R04
      .dem_odd (dem1),
      .dem_even(dem1),
      .out_odd (pulse_out_3),
      .out_even(pulse_out_2)
   );
   // =====================================
   // checks
   sequence s_stopped;
      !run_w ##1 !run_w;
   endsequence
   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      s_stopped |-> $stable(cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved"); // R05 R06
   property p_wrap;
      @(posedge hclk) disable iff (!hresetn)
      run_w && mode_w == MPC_FREE && at_top && !w_mode && !w_run
      |=> cnt_q == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap"); // R02
   property p_turn;
      @(posedge hclk) disable iff (!hresetn)
      turn_dn && !w_mode && !w_run |=> dir_q == MPC_DOWN && stat_q[0];
   endproperty
   a_turn: assert property (p_turn) else $error("no turn"); // R01
   property p_bot;
      @(posedge hclk) disable iff (!hresetn)
      bot_ev |=> stat_q[1];
   endproperty
   a_bot: assert property (p_bot) else $error("no bottom flag"); // R01
   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
      |(stat_q & mask_q) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing"); // R01
   property p_free_up;
      @(posedge hclk) disable iff (!hresetn)
      run_w && !ud_w |=> dir_q == MPC_UP;
   endproperty
   a_free_up: assert property (p_free_up) else $error("free dir"); // R08
   property p_ro_dir;
      @(posedge hclk) disable iff (!hresetn)
      w_run |=> run_q[6:0] == 7'h00;
   endproperty
   a_ro_dir: assert property (p_ro_dir) else $error("dir written"); // R09
   property p_ind_a;
      @(posedge hclk) disable iff (!hresetn)
      pair_q[0] && $stable(pair_q[0]) |=> pulse_out_1 == $past(dem0);
   endproperty
   a_ind_a: assert property (p_ind_a) else $error("pair a"); // R03
   property p_ind_b;
      @(posedge hclk) disable iff (!hresetn)
      pair_q[1] && $stable(pair_q[1]) |=> pulse_out_3 == $past(dem1);
   endproperty
   a_ind_b: assert property (p_ind_b) else $error("pair b"); // R04
endmodule : mpc_core
`default_nettype wire

// File: logic/mpc_regs.svh
// register offsets, field positions, reset values and counts for the pwm
// time-base and output-pair configuration block; definitions only
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH
// =====================================
// offsets (byte addresses, one word each)
`define MPC_OFS_MODE      12'h000
`define MPC_OFS_RUN       12'h004
`define MPC_OFS_PAIR      12'h008
`define MPC_OFS_PERIOD    12'h00C
`define MPC_OFS_DUTY0     12'h010
`define MPC_OFS_DUTY1     12'h014
`define MPC_OFS_IRQ_STAT  12'h018
`define MPC_OFS_IRQ_MASK  12'h01C
`define MPC_OFS_COUNT     12'h020
// =====================================
// fields
`define MPC_MODE_LSB      0
`define MPC_RUN_BIT       7
`define MPC_DIR_BIT       6
`define MPC_PAIR_A_BIT    0
`define MPC_PAIR_B_BIT    1
`define MPC_PAIR_C_BIT    2
`define MPC_IRQ_TOP_BIT   0
`define MPC_IRQ_BOT_BIT   1
// =====================================
// reset values and the dead-time cycle count
`define MPC_RST_MODE      8'h00
`define MPC_RST_RUN       8'h00
`define MPC_RST_PAIR      8'h00
`define MPC_RST_PERIOD    12'hFFF
`define MPC_RST_DUTY      12'h000
`define MPC_RST_MASK      2'h0
`define MPC_DEAD_CYCLES   4'h4
`endif

// File: logic/mpc_pkg.sv
// types shared by the pwm configuration block
// assumes the _regs header supplies all numeric constants
`default_nettype none
package mpc_pkg;
   typedef enum logic [1:0] {
      MPC_FREE  = 2'b00,
      MPC_UD    = 2'b10,
      MPC_UD_DB = 2'b11
   } mpc_mode_t;
   typedef enum logic [1:0] {
      MPC_UP   = 2'b01,
      MPC_DOWN = 2'b10
   } mpc_dir_t;
endpackage : mpc_pkg
`default_nettype wire

// File: logic/mpc_pair.sv
// one output pair: independent or complementary with dead time
// assumes single clock, raw demand levels from the compare logic
`timescale 1ns/1ns
`default_nettype none
`include "mpc_regs.svh"
module mpc_pair #(
   parameter int           DW   = 4,
   parameter logic [DW-1:0] DEAD = `MPC_DEAD_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic indep,
   input  wire logic dem_odd,
   input  wire logic dem_even,
   output logic      out_odd,
   output logic      out_even
);
   logic          prev_q;
   logic [DW-1:0] dead_q;
   wire  logic    edge_w = dem_odd != prev_q;
   wire  logic    odd_d  = indep ? dem_odd : (dem_odd && dead_q == '0);
   wire  logic    even_d = indep ? dem_even : (!dem_odd && dead_q == '0);
   // =====================================
   // dead time on every demand edge in complementary mode: both sides held off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q   <= 1'b0;
         dead_q   <= '0;
         out_odd  <= 1'b0;
         out_even <= 1'b0;
      end else begin
         prev_q   <= dem_odd;
         dead_q   <= edge_w ? DEAD : (dead_q != '0 ? dead_q - 1'b1 : dead_q); // R07
         out_odd  <= indep ? dem_odd : (!edge_w && odd_d);  // R07
         out_even <= indep ? dem_even : (!edge_w && even_d); // R07
      end
   end
   property p_no_overlap;
      @(posedge hclk) disable iff (!hresetn)
      !indep |-> !(out_odd && out_even);
   endproperty
   a_no_overlap: assert property (p_no_overlap) // R07
      else $error("pair overlap");
endmodule : mpc_pair
`default_nettype wire

// File: tb/mpc_stage_model.sv
// model of the power stages hanging on the four pulse outputs
// assumes the bench says which pairs are complementary
`timescale 1ns/1ns
`default_nettype none
module mpc_stage_model (
   input  wire logic       hclk,
   input  wire logic       comp_a,
   input  wire logic       comp_b,
   input  wire logic [3:0] p,
   output int              faults,
   output int              highs
);
   int lo [4];
   initial begin
      faults = 0;
      highs = 0;
      foreach (lo[i]) lo[i] = 0;
   end
   // =====================================
   // shoot-through and dead gap watch
   always @(posedge hclk) begin
      for (int i = 0; i < 4; i++) begin
         if (i < 2 ? comp_a : comp_b) begin
            if (p[i] && p[i^1]) faults++;
            if (p[i] && lo[i] > 0 && lo[i^1] < 4) faults++;
         end else if (p[i] !== p[i^1]) faults++;
         if (p[i]) highs++;
      end
      // counted after the checks so a rise sees the old gap
      for (int i = 0; i < 4; i++) lo[i] = p[i] ? 0 : lo[i] + 1;
   end
endmodule // mpc_stage_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the pwm configuration block
// assumes one ahb-lite slave, so hready is the slave's hreadyout
`timescale 1ns/1ns
`default_nettype none
`include "mpc_regs.svh"
module tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [11:0] haddr = '0, per, c1;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = '0, hrdata, rd, d;
   // pair setting out of reset is complementary on both pairs
   logic        hreadyout, hresp, irq, comp_a = 1, comp_b = 1;
   logic [3:0]  p;
   int          miscompares = 0, check_count = 0, cycles = 0;
   int          faults, highs, seen;
   integer      seed = 32'h1372;
   always #2 hclk = ~hclk;
   mpc_core mpc_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .pulse_out_0(p[0]), .pulse_out_1(p[1]), .pulse_out_2(p[2]),
      .pulse_out_3(p[3]));
   mpc_stage_model mpc_stage_model_inst (.hclk(hclk), .comp_a(comp_a),
      .comp_b(comp_b), .p(p), .faults(faults), .highs(highs));
   // =====================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // entered just after a rising edge; ready sampled at rising edges
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
      xfer(1'b0, a, '0);
      chk(nm, e, rd);
      chk("hresp", '0, 32'(hresp));
   endtask
   function automatic logic [31:0] exp_stat(input logic [1:0] m);
      return (m == 2'b11) ? 32'h3 : 32'h1;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         final_report();
      end
   end
   // =====================================
   // one run of the time base in a given mode and pair setting
   task automatic run_mode(input logic [1:0] m, input logic [2:0] pr);
      per = 12'd16 + 12'($unsigned($random(seed)) % 32);
      xfer(1'b1, `MPC_OFS_PERIOD, 32'(per));
      xfer(1'b1, `MPC_OFS_DUTY0, 32'(per / 2));
      xfer(1'b1, `MPC_OFS_DUTY1, 32'(per / 3));
      xfer(1'b1, `MPC_OFS_MODE, 32'(m));
      xfer(1'b1, `MPC_OFS_PAIR, 32'(pr));
      // outputs follow the new pair setting one edge after it lands
      @(posedge hclk);
      comp_a <= !pr[0];
      comp_b <= !pr[1];
      xfer(1'b1, `MPC_OFS_IRQ_MASK, 32'h3);
      xfer(1'b1, `MPC_OFS_RUN, 32'h80);
      seen = 0;
      repeat (48) begin
         xfer(1'b0, `MPC_OFS_RUN, '0);
         if (rd[6] === 1'b1) seen++;
      end
      chk("count_down", 32'(m[1]), 32'(seen > 0));
      chk("irq", 32'h1, 32'(irq));
      xfer(1'b1, `MPC_OFS_RUN, '0);
      xfer(1'b0, `MPC_OFS_COUNT, '0);
      c1 = rd[11:0];
      repeat (20) @(posedge hclk);
      rdchk("count held", `MPC_OFS_COUNT, 32'(c1));
      chk("count range", 32'h1, 32'(c1 <= per));
      rdchk("status", `MPC_OFS_IRQ_STAT, exp_stat(m));
      rdchk("status cleared", `MPC_OFS_IRQ_STAT, '0);
      repeat (2) @(negedge hclk);
      chk("irq off", '0, 32'(irq));
      @(posedge hclk);
      $display("run test mode %b pairs %b done", m, pr);
   endtask
   // =====================================
   // main sequence
   logic [1:0] modes [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
   logic [2:0] pairs [4] = '{3'h2, 3'h1, 3'h0, 3'h3};
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("mode reset", `MPC_OFS_MODE, '0);
      rdchk("run reset", `MPC_OFS_RUN, '0);
      rdchk("pair reset", `MPC_OFS_PAIR, '0);
      rdchk("mask reset", `MPC_OFS_IRQ_MASK, '0);
      repeat (30) @(posedge hclk);
      rdchk("count idle", `MPC_OFS_COUNT, '0);
      rdchk("unmapped", 12'h040, '0);
      $display("reset test done");
      xfer(1'b1, `MPC_OFS_RUN, 32'h40);
      rdchk("flag write", `MPC_OFS_RUN, '0);
      d = 32'($unsigned($random(seed)) % 256);
      xfer(1'b1, `MPC_OFS_MODE, d);
      rdchk("mode store", `MPC_OFS_MODE, d);
      $display("register test done");
      for (int i = 0; i < 4; i++) run_mode(modes[i], pairs[i]);
      chk("stage faults", '0, 32'(faults));
      chk("outputs active", 32'h1, 32'(highs > 0));
      final_report();
   end
endmodule // tb
`default_nettype wire
